// file: logic/spawner_pkg.sv
// shared constants, register map and carrier types of the root spawner
package spawner_pkg;
  localparam int ROOTQ_DEPTH = 4;
  localparam int CHILDQ_DEPTH = 8;
  localparam int L1_WAYS = 4;
  localparam int SLOTS = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SBASE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DCNT = 8'h0c;
  // control fields
  localparam int CTRL_MAX_LSB = 0;
  localparam int CTRL_CHILD_BIT = 8;
  localparam int CTRL_SB_BIT = 9;
  localparam int CTRL_SSIZE_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] SBASE_RST = 32'h0000_0000;
  // status fields
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_RQ_LSB = 8;
  localparam int STAT_CQ_LSB = 16;
  localparam int STAT_BUSY_BIT = 24;
  // descriptor bit asking for scratch memory
  localparam int DESC_SCRATCH_BIT = 0;
  localparam logic [3:0] MAX_SLOTS = 4'h8;

  typedef struct packed {
    logic [4:0] desc_ptr;
    logic [7:0] handle;
    logic sync;
    logic ext;
  } root_req_s;

  typedef struct packed {
    logic spawn_root;
    logic [4:0] desc_ptr;
    logic [15:0] urb_ptr;
  } child_req_s;

  typedef enum logic [0:0] {
    MSG_TERM = 1'b0,
    MSG_REL = 1'b1
  } msg_kind_e;

  typedef struct packed {
    msg_kind_e kind;
    logic [2:0] slot;
  } thread_msg_s;

  typedef struct packed {
    logic is_root;
    logic [31:0] desc;
    logic [15:0] urb_ptr;
    logic [31:0] scratch_ptr;
    logic [2:0] slot;
    logic [7:0] ret_handle;
    logic ret_valid;
  } disp_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOKUP = 3'b001,
    ST_L2 = 3'b010,
    ST_CHECK = 3'b011,
    ST_DISP = 3'b100
  } eng_e;
endpackage : spawner_pkg

// file: logic/root_thread_spawner.sv
// root-thread spawner: queues, descriptor cache, dispatch and root tracking
//
// What this block does
// - root queue arbitrates only below root maximum
// - four-entry associative descriptor cache, misses go L2
// - descriptors come back in request order
// - recheck root maximum after descriptor arrives
// - make scratch pointer when root wants scratch
// - build dispatch record (slot, return handle), then request dispatch
// - track roots; termination frees scratch and slot
// - accept handle release before root terminates
// - child mode clear: release handle at dispatch ack
// - child mode set: handle returned, released on message
// - limit only roots, never child threads
// - one shared scratch size for all roots
// - sync flag marks synchronized root, same queue
// - sync root waits for spawn-root at child head
// - spawn-root head blocks child queue until pairing
// - paired heads leave both queues same cycle
// - extended sync root also needs scoreboard ready
// - child queue served before root queue
// - child queue eight deep; pop pulses return credit
module root_thread_spawner (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // root requests from the front_end_unit
  input wire logic i_root_valid,
  input wire spawner_pkg::root_req_s i_root_req,
  output logic o_root_ready,
  // child queue messages from the message bus
  input wire logic i_child_valid,
  input wire spawner_pkg::child_req_s i_child_req,
  output logic o_child_ready,
  output logic o_child_pop,
  // thread messages (termination, resource release)
  input wire logic i_msg_valid,
  input wire spawner_pkg::thread_msg_s i_msg,
  output logic o_msg_ready,
  // second-level descriptor cache
  output logic o_l2_req,
  output logic [4:0] o_l2_ptr,
  input wire logic i_l2_rvalid,
  input wire logic [31:0] i_l2_desc,
  // hardware scoreboard
  input wire logic i_sb_ready,
  // thread_dispatcher_unit
  output logic o_disp_valid,
  output spawner_pkg::disp_s o_disp,
  input wire logic i_disp_ack,
  // return_buffer handle release to the front_end_unit
  output logic o_rel_valid,
  output logic [7:0] o_rel_handle
);
  import spawner_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  function automatic logic [3:0] eff_max(input logic [31:0] ctrl);
    logic [3:0] m;
    m = ctrl[CTRL_MAX_LSB +: 4];
    return (m > MAX_SLOTS) ? MAX_SLOTS : m;
  endfunction : eff_max

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] ctrl_ff, nxt_ctrl, sbase_ff, nxt_sbase, dcnt_ff, nxt_dcnt;
  logic [31:0] wbdat_ff, nxt_wbdat;
  logic ack_ff, nxt_ack;
  root_req_s rq_mem [ROOTQ_DEPTH];
  child_req_s cq_mem [CHILDQ_DEPTH];
  logic [1:0] rq_rd_ff, nxt_rq_rd, rq_wr_ff, nxt_rq_wr;
  logic [2:0] rq_cnt_ff, nxt_rq_cnt;
  logic [2:0] cq_rd_ff, nxt_cq_rd, cq_wr_ff, nxt_cq_wr;
  logic [3:0] cq_cnt_ff, nxt_cq_cnt;
  logic [4:0] tag_ff [L1_WAYS];
  logic [31:0] dat_ff [L1_WAYS];
  logic [L1_WAYS-1:0] tv_ff, nxt_tv;
  logic [1:0] rr_ff, nxt_rr;
  eng_e st_ff, nxt_st;
  logic cur_root_ff, nxt_cur_root, cur_sync_ff, nxt_cur_sync;
  logic cur_ext_ff, nxt_cur_ext;
  logic [4:0] cur_ptr_ff, nxt_cur_ptr;
  logic [7:0] cur_hdl_ff, nxt_cur_hdl;
  logic [15:0] cur_urb_ff, nxt_cur_urb;
  logic [31:0] desc_ff, nxt_desc;
  disp_s disp_ff, nxt_disp;
  logic [SLOTS-1:0] sv_ff, nxt_sv, srel_ff, nxt_srel;
  logic [7:0] shdl_ff [SLOTS];
  logic [3:0] cnt_ff, nxt_cnt;
  logic rel_ff, nxt_rel, pop_ff, nxt_pop;
  logic [7:0] relh_ff, nxt_relh;
  logic rq_push, cq_push, rq_pop, cq_pop, fill, hit;
  logic [1:0] hit_idx;
  logic [2:0] free_slot;
  logic room, child_mode, sb_ok, ack_rel, wr_hit;
  root_req_s rq_head;
  child_req_s cq_head;

  assign child_mode = ctrl_ff[CTRL_CHILD_BIT];
  assign rq_head = rq_mem[rq_rd_ff];
  assign cq_head = cq_mem[cq_rd_ff];
  assign room = cnt_ff < eff_max(ctrl_ff);
  assign o_root_ready = rq_cnt_ff != 3'(ROOTQ_DEPTH);
  assign o_child_ready = cq_cnt_ff != 4'(CHILDQ_DEPTH);
  assign rq_push = i_root_valid && o_root_ready;
  assign cq_push = i_child_valid && o_child_ready;
  // a release at dispatch owns the release port; messages wait that cycle
  assign ack_rel = st_ff == ST_DISP && i_disp_ack && cur_root_ff &&
    !child_mode;
  assign o_msg_ready = !ack_rel;
  assign o_l2_req = st_ff == ST_L2;
  assign o_l2_ptr = cur_ptr_ff;
  assign o_disp_valid = st_ff == ST_DISP;
  assign o_disp = disp_ff;
  assign o_rel_valid = rel_ff;
  assign o_rel_handle = relh_ff;
  assign o_child_pop = pop_ff;
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = wbdat_ff;
  assign sb_ok = !(cur_sync_ff && cur_ext_ff && ctrl_ff[CTRL_SB_BIT]) ||
    i_sb_ready;

  // ----------------------------------------
  // cache lookup and free slot search
  // ----------------------------------------
  always_comb
  begin
    hit = 1'b0;
    hit_idx = 2'h0;
    for (int i = 0; i < L1_WAYS; i++)
    begin
      if (tv_ff[i] && tag_ff[i] == cur_ptr_ff && !hit)
      begin
        hit = 1'b1;
        hit_idx = 2'(i);
      end
    end
    free_slot = 3'h0;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (!sv_ff[i])
      begin
        free_slot = 3'(i);
      end
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  always_comb
  begin
    nxt_ack = i_wb_cyc && i_wb_stb && !ack_ff;
    wr_hit = i_wb_cyc && i_wb_stb && i_wb_we && ack_ff;
    nxt_ctrl = ctrl_ff;
    nxt_sbase = sbase_ff;
    if (wr_hit && i_wb_adr == OFS_CTRL)
    begin
      nxt_ctrl = lane_merge(ctrl_ff, i_wb_dat, i_wb_sel);
    end
    if (wr_hit && i_wb_adr == OFS_SBASE)
    begin
      nxt_sbase = lane_merge(sbase_ff, i_wb_dat, i_wb_sel);
    end
    nxt_wbdat = wbdat_ff;
    if (nxt_ack)
    begin
      case (i_wb_adr)
        OFS_CTRL: nxt_wbdat = ctrl_ff;
        OFS_SBASE: nxt_wbdat = sbase_ff;
        OFS_STATUS: nxt_wbdat = {7'h0, st_ff != ST_IDLE, 4'h0, cq_cnt_ff,
          5'h0, rq_cnt_ff, 4'h0, cnt_ff};
        OFS_DCNT: nxt_wbdat = dcnt_ff;
        default: nxt_wbdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ack_ff <= 1'b0;
      ctrl_ff <= CTRL_RST;
      sbase_ff <= SBASE_RST;
      wbdat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= nxt_ack;
      ctrl_ff <= nxt_ctrl;
      sbase_ff <= nxt_sbase;
      wbdat_ff <= nxt_wbdat;
    end
  end

  // ----------------------------------------
  // dispatch engine
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    rq_pop = 1'b0;
    cq_pop = 1'b0;
    fill = 1'b0;
    nxt_cur_root = cur_root_ff;
    nxt_cur_sync = cur_sync_ff;
    nxt_cur_ext = cur_ext_ff;
    nxt_cur_ptr = cur_ptr_ff;
    nxt_cur_hdl = cur_hdl_ff;
    nxt_cur_urb = cur_urb_ff;
    nxt_desc = desc_ff;
    nxt_disp = disp_ff;
    nxt_tv = tv_ff;
    nxt_rr = rr_ff;
    nxt_dcnt = dcnt_ff;
    case (st_ff)
      ST_IDLE:
      begin
        if (cq_cnt_ff != 4'h0 && !cq_head.spawn_root)
        begin
          cq_pop = 1'b1;
          nxt_cur_root = 1'b0;
          nxt_cur_sync = 1'b0;
          nxt_cur_ext = 1'b0;
          nxt_cur_ptr = cq_head.desc_ptr;
          nxt_cur_urb = cq_head.urb_ptr;
          nxt_st = ST_LOOKUP;
        end
        else if (rq_cnt_ff != 3'h0 && room)
        begin
          // sync root only leaves paired with a spawn-root head
          if (!rq_head.sync || (cq_cnt_ff != 4'h0 && cq_head.spawn_root))
          begin
            rq_pop = 1'b1;
            cq_pop = rq_head.sync;
            nxt_cur_root = 1'b1;
            nxt_cur_sync = rq_head.sync;
            nxt_cur_ext = rq_head.ext;
            nxt_cur_ptr = rq_head.desc_ptr;
            nxt_cur_hdl = rq_head.handle;
            nxt_cur_urb = 16'h0;
            nxt_st = ST_LOOKUP;
          end
        end
      end
      ST_LOOKUP:
      begin
        if (hit)
        begin
          nxt_desc = dat_ff[hit_idx];
          nxt_st = ST_CHECK;
        end
        else
        begin
          nxt_st = ST_L2;
        end
      end
      ST_L2:
      begin
        // one lookup in flight keeps descriptors in request order
        if (i_l2_rvalid)
        begin
          fill = 1'b1;
          nxt_desc = i_l2_desc;
          nxt_tv[rr_ff] = 1'b1;
          nxt_rr = rr_ff + 2'h1;
          nxt_st = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        nxt_disp.is_root = cur_root_ff;
        nxt_disp.desc = desc_ff;
        nxt_disp.urb_ptr = cur_urb_ff;
        nxt_disp.scratch_ptr = 32'h0;
        nxt_disp.slot = 3'h0;
        nxt_disp.ret_handle = 8'h0;
        nxt_disp.ret_valid = 1'b0;
        if (!cur_root_ff)
        begin
          nxt_st = ST_DISP;
        end
        else if (room && sb_ok)
        begin
          nxt_disp.slot = free_slot;
          nxt_disp.ret_handle = child_mode ? cur_hdl_ff : 8'h0;
          nxt_disp.ret_valid = child_mode;
          if (desc_ff[DESC_SCRATCH_BIT])
          begin
            nxt_disp.scratch_ptr = sbase_ff + (32'(free_slot) <<
              ctrl_ff[CTRL_SSIZE_LSB +: 4]);
          end
          nxt_st = ST_DISP;
        end
      end
      ST_DISP:
      begin
        if (i_disp_ack)
        begin
          nxt_dcnt = dcnt_ff + 32'h1;
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff <= ST_IDLE;
      cur_root_ff <= 1'b0;
      cur_sync_ff <= 1'b0;
      cur_ext_ff <= 1'b0;
      cur_ptr_ff <= 5'h0;
      cur_hdl_ff <= 8'h0;
      cur_urb_ff <= 16'h0;
      desc_ff <= 32'h0;
      disp_ff <= '0;
      tv_ff <= '0;
      rr_ff <= 2'h0;
      dcnt_ff <= 32'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      cur_root_ff <= nxt_cur_root;
      cur_sync_ff <= nxt_cur_sync;
      cur_ext_ff <= nxt_cur_ext;
      cur_ptr_ff <= nxt_cur_ptr;
      cur_hdl_ff <= nxt_cur_hdl;
      cur_urb_ff <= nxt_cur_urb;
      desc_ff <= nxt_desc;
      disp_ff <= nxt_disp;
      tv_ff <= nxt_tv;
      rr_ff <= nxt_rr;
      dcnt_ff <= nxt_dcnt;
    end
  end

  // cache storage needs no reset: valid bits guard it
  always_ff @(posedge i_sys_clk)
  begin
    if (fill)
    begin
      tag_ff[rr_ff] <= cur_ptr_ff;
      dat_ff[rr_ff] <= i_l2_desc;
    end
  end

  // ----------------------------------------
  // queues
  // ----------------------------------------
  always_comb
  begin
    nxt_rq_wr = rq_wr_ff + 2'(rq_push);
    nxt_rq_rd = rq_rd_ff + 2'(rq_pop);
    nxt_rq_cnt = rq_cnt_ff + 3'(rq_push) - 3'(rq_pop);
    nxt_cq_wr = cq_wr_ff + 3'(cq_push);
    nxt_cq_rd = cq_rd_ff + 3'(cq_pop);
    nxt_cq_cnt = cq_cnt_ff + 4'(cq_push) - 4'(cq_pop);
    nxt_pop = cq_pop;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rq_wr_ff <= 2'h0;
      rq_rd_ff <= 2'h0;
      rq_cnt_ff <= 3'h0;
      cq_wr_ff <= 3'h0;
      cq_rd_ff <= 3'h0;
      cq_cnt_ff <= 4'h0;
      pop_ff <= 1'b0;
    end
    else
    begin
      rq_wr_ff <= nxt_rq_wr;
      rq_rd_ff <= nxt_rq_rd;
      rq_cnt_ff <= nxt_rq_cnt;
      cq_wr_ff <= nxt_cq_wr;
      cq_rd_ff <= nxt_cq_rd;
      cq_cnt_ff <= nxt_cq_cnt;
      pop_ff <= nxt_pop;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (rq_push)
    begin
      rq_mem[rq_wr_ff] <= i_root_req;
    end
    if (cq_push)
    begin
      cq_mem[cq_wr_ff] <= i_child_req;
    end
  end

  // ----------------------------------------
  // root tracking and handle release
  // ----------------------------------------
  always_comb
  begin
    logic disp_root, term, rel_msg;
    disp_root = st_ff == ST_DISP && i_disp_ack && cur_root_ff;
    term = i_msg_valid && o_msg_ready && i_msg.kind == MSG_TERM &&
      sv_ff[i_msg.slot];
    rel_msg = i_msg_valid && o_msg_ready && i_msg.kind == MSG_REL &&
      sv_ff[i_msg.slot] && !srel_ff[i_msg.slot];
    nxt_sv = sv_ff;
    nxt_srel = srel_ff;
    nxt_rel = 1'b0;
    nxt_relh = relh_ff;
    if (term)
    begin
      nxt_sv[i_msg.slot] = 1'b0;
    end
    if (rel_msg)
    begin
      nxt_srel[i_msg.slot] = 1'b1;
      nxt_rel = 1'b1;
      nxt_relh = shdl_ff[i_msg.slot];
    end
    if (disp_root)
    begin
      nxt_sv[disp_ff.slot] = 1'b1;
      nxt_srel[disp_ff.slot] = !child_mode;
    end
    if (ack_rel)
    begin
      nxt_rel = 1'b1;
      nxt_relh = cur_hdl_ff;
    end
    nxt_cnt = cnt_ff + 4'(disp_root) - 4'(term);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sv_ff <= '0;
      srel_ff <= '0;
      cnt_ff <= 4'h0;
      rel_ff <= 1'b0;
      relh_ff <= 8'h0;
    end
    else
    begin
      sv_ff <= nxt_sv;
      srel_ff <= nxt_srel;
      cnt_ff <= nxt_cnt;
      rel_ff <= nxt_rel;
      relh_ff <= nxt_relh;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (st_ff == ST_DISP && i_disp_ack && cur_root_ff)
    begin
      shdl_ff[disp_ff.slot] <= cur_hdl_ff;
    end
  end
endmodule : root_thread_spawner

// file: sim/far_side_model.sv
// far-side model: second-level descriptor cache and thread dispatcher
module far_side_model
  import spawner_pkg::*;
(
  // clock, reset and pace
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_slow,
  // descriptor fetch
  input wire logic i_l2_req,
  input wire logic [4:0] i_l2_ptr,
  output logic o_l2_rvalid,
  output logic [31:0] o_l2_desc,
  // dispatch handshake
  input wire logic i_disp_valid,
  output logic o_disp_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lcnt_ff;
  logic [1:0] dcnt_ff;
  // -------------------------------------------
  // answers after 1 cycle, or 3 when slow
  // -------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      lcnt_ff <= 2'h0;
      dcnt_ff <= 2'h0;
      o_l2_rvalid <= 1'b0;
      o_disp_ack <= 1'b0;
      o_l2_desc <= 32'h0;
    end
    else
    begin
      o_l2_rvalid <= 1'b0;
      o_disp_ack <= 1'b0;
      // idle bus keeps changing so stale data is never trusted
      o_l2_desc <= ~o_l2_desc;
      lcnt_ff <= 2'h0;
      dcnt_ff <= 2'h0;
      if (i_l2_req && !o_l2_rvalid)
      begin
        lcnt_ff <= lcnt_ff + 2'h1;
        if (lcnt_ff >= {i_slow, 1'b0})
        begin
          o_l2_rvalid <= 1'b1;
          o_l2_desc <= {27'h0, i_l2_ptr};
        end
      end
      if (i_disp_valid && !o_disp_ack)
      begin
        dcnt_ff <= dcnt_ff + 2'h1;
        o_disp_ack <= dcnt_ff >= {i_slow, 1'b0};
      end
    end
endmodule : far_side_model

// file: sim/root_thread_spawner_checker.sv
// port assertions of the root thread spawner
module root_thread_spawner_checker
  import spawner_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_msg_valid,
  input wire spawner_pkg::thread_msg_s i_msg,
  input wire logic o_msg_ready,
  input wire logic o_l2_req,
  input wire logic [4:0] o_l2_ptr,
  input wire logic i_l2_rvalid,
  input wire logic o_disp_valid,
  input wire spawner_pkg::disp_s o_disp,
  input wire logic i_disp_ack,
  input wire logic o_rel_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic ack_ff;
  logic relm_ff;
  logic nxt_ack;
  logic nxt_relm;
  always_comb
  begin
    // only a root dispatch without a return handle may release at once
    nxt_ack = o_disp_valid && i_disp_ack && o_disp.is_root &&
      !o_disp.ret_valid;
    nxt_relm = i_msg_valid && o_msg_ready && i_msg.kind == MSG_REL;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      ack_ff <= 1'b0;
      relm_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= nxt_ack;
      relm_ff <= nxt_relm;
    end
  chk_wb_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("wishbone ack late");
  chk_disp_hold: assert property (o_disp_valid && !i_disp_ack
    |=> o_disp_valid && $stable(o_disp)) else $error("dispatch dropped");
  chk_desc_first: assert property (o_l2_req && i_l2_rvalid
    |=> !o_disp_valid && !o_l2_req) else $error("dispatch before check");
  chk_l2_hold: assert property (o_l2_req && !i_l2_rvalid
    |=> o_l2_req && $stable(o_l2_ptr)) else $error("fetch dropped");
  chk_rel_cause: assert property (o_rel_valid
    |-> ack_ff || relm_ff) else $error("release without cause");
  chk_root_release: assert property (o_disp_valid && i_disp_ack
    && o_disp.is_root && !o_disp.ret_valid |=> o_rel_valid)
    else $error("no release at dispatch");
  chk_child_hold: assert property (o_disp_valid && i_disp_ack
    && o_disp.ret_valid && !i_msg_valid |=> !o_rel_valid)
    else $error("handle released at dispatch");
  chk_msg_block: assert property (!o_msg_ready
    |-> o_disp_valid && i_disp_ack) else $error("messages refused");
endmodule : root_thread_spawner_checker

// file: sim/root_thread_spawner_tb.sv
// self-checking bench of the root thread spawner
module root_thread_spawner_tb
  import spawner_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [4:0] p; logic [7:0] h;} row_s;
  typedef struct packed {logic [7:0] a; logic [31:0] e;} reg_s;
  row_s rows[7] = '{'{5'h03, 8'h11}, '{5'h03, 8'h22}, '{5'h04, 8'h33},
    '{5'h09, 8'h44}, '{5'h0a, 8'h55}, '{5'h0c, 8'h66}, '{5'h03, 8'h77}};
  reg_s regs[3] = '{'{OFS_CTRL, CTRL_RST}, '{OFS_SBASE, SBASE_RST},
    '{8'h40, 32'h0}};
  logic clk = 1'b0;
  logic rst_b, cyc, stb, we, rv, cv, mv, sb, slow;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, l2d;
  root_req_s rr;
  child_req_s cr;
  thread_msg_s mg;
  logic ack, rrdy, crdy, pop, mrdy, l2q, l2v, dv, dack, relv;
  logic [4:0] l2p;
  logic [7:0] relh;
  disp_s dd;
  int bad_count, compares, nd, nr, np, tk, tr;
  disp_s dq[$];
  logic [7:0] rq[$];
  always #2 clk = ~clk;
  root_thread_spawner dut_u (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_root_valid(rv), .i_root_req(rr), .o_root_ready(rrdy),
    .i_child_valid(cv), .i_child_req(cr), .o_child_ready(crdy),
    .o_child_pop(pop), .i_msg_valid(mv), .i_msg(mg), .o_msg_ready(mrdy),
    .o_l2_req(l2q), .o_l2_ptr(l2p), .i_l2_rvalid(l2v), .i_l2_desc(l2d),
    .i_sb_ready(sb), .o_disp_valid(dv), .o_disp(dd), .i_disp_ack(dack),
    .o_rel_valid(relv), .o_rel_handle(relh));
  far_side_model m_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_slow(slow),
    .i_l2_req(l2q), .i_l2_ptr(l2p), .o_l2_rvalid(l2v), .o_l2_desc(l2d),
    .i_disp_valid(dv), .o_disp_ack(dack));
  always @(posedge clk)
  begin
    if (dv && dack)
      dq.push_back(dd);
    nd += int'(dv && dack);
    if (relv)
      rq.push_back(relh);
    nr += int'(relv);
    np += int'(pop);
  end
  task report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task hang(input string n);
    bad_count++;
    $display("MISMATCH %s expected done seen timeout", n);
    report_and_stop();
  endtask : hang
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      hang("wishbone");
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // one handshake: 0 root, 1 child, 2 thread message
  task push(input int k);
    int n;
    @(posedge clk);
    {rv, cv, mv} <= 3'b100 >> k;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((k == 0 ? rrdy : k == 1 ? crdy : mrdy) !== 1'b1 && n < 50);
    if (n >= 50)
      hang("handshake");
    {rv, cv, mv} <= 3'b000;
  endtask : push
  task upto(input int w, input int k);
    int n;
    n = 0;
    while ((w ? nr : nd) < k && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300)
      hang("completion");
  endtask : upto
  task take(output disp_s d);
    upto(0, tk + 1);
    d = dq.pop_front();
    tk++;
  endtask : take
  task getrel(output logic [7:0] h);
    upto(1, tr + 1);
    h = rq.pop_front();
    tr++;
  endtask : getrel
  task msg(input logic [2:0] s, input msg_kind_e k);
    mg <= '{k, s};
    push(2);
  endtask : msg
  task root(input logic [4:0] p, input logic [7:0] h, input logic s, e);
    rr <= '{p, h, s, e};
    push(0);
  endtask : root
  task spawn(input logic s, input logic [4:0] p);
    cr <= '{s, p, 16'h0};
    push(1);
  endtask : spawn
  task idle_chk(input string n);
    repeat (20) @(posedge clk);
    chk(n, tk, nd);
  endtask : idle_chk
  initial
  begin
    repeat (50000) @(posedge clk);
    hang("run");
  end
  initial
  begin
    logic [31:0] q;
    logic [7:0] h;
    disp_s d;
    logic [2:0] s;
    {rst_b, cyc, stb, we, rv, cv, mv, sb, slow} = 9'h0;
    {adr, sel, wdat, rr, cr, mg} = {8'h0, 4'hf, 32'h0, 15'h0, 22'h0, 4'h0};
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i])
    begin
      wb(1'b0, regs[i].a, 32'h0, q);
      chk("register", regs[i].e, q);
    end
    wb(1'b1, OFS_SBASE, 32'h0001_0000, q);
    wb(1'b1, OFS_CTRL, 32'h0004_0008, q);
    foreach (rows[i])
    begin
      slow <= i[0];
      root(rows[i].p, rows[i].h, 1'b0, 1'b0);
      take(d);
      chk("desc", {27'h0, rows[i].p}, d.desc);
      chk("root", 1, d.is_root);
      if (rows[i].p[0])
        chk("scratch", 32'h0001_0000 + {25'h0, d.slot, 4'h0},
          d.scratch_ptr);
      getrel(h);
      chk("release", rows[i].h, h);
      msg(d.slot, MSG_TERM);
    end
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk("count", 0, q[3:0]);
    // -------------------------------------------
    // limit of one root: second waits for the end
    // -------------------------------------------
    wb(1'b1, OFS_CTRL, 32'h0004_0001, q);
    root(5'h06, 8'h61, 1'b0, 1'b0);
    root(5'h07, 8'h62, 1'b0, 1'b0);
    take(d);
    idle_chk("held");
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk("count", 1, q[3:0]);
    getrel(h);
    msg(d.slot, MSG_TERM);
    take(d);
    chk("desc", 7, d.desc);
    getrel(h);
    msg(d.slot, MSG_TERM);
    // child mode: handle kept until release message
    wb(1'b1, OFS_CTRL, 32'h0004_0108, q);
    root(5'h08, 8'h5a, 1'b0, 1'b0);
    take(d);
    chk("return", 9'h15a, {d.ret_valid, d.ret_handle});
    repeat (10) @(posedge clk);
    chk("kept", tr, nr);
    msg(d.slot, MSG_REL);
    getrel(h);
    chk("release", 8'h5a, h);
    msg(d.slot, MSG_TERM);
    // -------------------------------------------
    // synchronized roots and spawn-root pairing
    // -------------------------------------------
    wb(1'b1, OFS_CTRL, 32'h0004_0008, q);
    root(5'h09, 8'h71, 1'b1, 1'b0);
    idle_chk("sync held");
    spawn(1'b1, 5'h0);
    take(d);
    chk("paired", 1, np);
    getrel(h);
    msg(d.slot, MSG_TERM);
    wb(1'b1, OFS_CTRL, 32'h0004_0208, q);
    root(5'h0a, 8'h72, 1'b1, 1'b1);
    spawn(1'b1, 5'h0);
    idle_chk("scoreboard");
    // plain root and plain child queue up behind the stalled root
    root(5'h03, 8'h74, 1'b0, 1'b0);
    spawn(1'b0, 5'h04);
    sb <= 1'b1;
    take(d);
    chk("desc", 10, d.desc);
    getrel(h);
    msg(d.slot, MSG_TERM);
    take(d);
    chk("child first", 32'h04, d.desc);
    chk("child root", 0, d.is_root);
    take(d);
    chk("root after", 32'h03, d.desc);
    getrel(h);
    chk("release", 8'h74, h);
    msg(d.slot, MSG_TERM);
    // spawn-root at the head blocks a plain child behind it
    spawn(1'b1, 5'h0);
    spawn(1'b0, 5'h0b);
    idle_chk("blocked");
    root(5'h0c, 8'h73, 1'b1, 1'b0);
    take(d);
    chk("sync first", 1, d.is_root);
    s = d.slot;
    take(d);
    chk("child", 32'h0b, d.desc);
    chk("child root", 0, d.is_root);
    getrel(h);
    chk("release", 8'h73, h);
    msg(s, MSG_TERM);
    report_and_stop();
  end
endmodule : root_thread_spawner_tb
bind root_thread_spawner root_thread_spawner_checker chk_u (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_msg_valid(i_msg_valid),
  .i_msg(i_msg), .o_msg_ready(o_msg_ready), .o_l2_req(o_l2_req),
  .o_l2_ptr(o_l2_ptr), .i_l2_rvalid(i_l2_rvalid),
  .o_disp_valid(o_disp_valid), .o_disp(o_disp), .i_disp_ack(i_disp_ack),
  .o_rel_valid(o_rel_valid));
